//--- pcc_checker.sv
// Bus and output assertions for the PWM channel counter.
`timescale 1ns/100ps
module pcc_checker
(
	// Clock and reset
	input wire        clk,
	input wire        rst_n,
	// Bus handshakes
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Channel outputs
	input wire        primary_channel,
	input wire        channel_irq,
	input wire        pair_active,
	input wire [1:0]  partner_clock_sel,
	input wire        partner_clear_mask
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("late read data");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("bad write answer");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read not closed");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write not closed");
	property p_ar_blk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_blk: assert property (p_ar_blk) else $error("read overlap");
	property p_upper;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper data set");
	property p_pair;
		!pair_active |-> partner_clock_sel == 2'b00 && !partner_clear_mask;
	endproperty
	a_pair: assert property (p_pair) else $error("partner driven");
	property p_idle;
		$rose(rst_n) |-> primary_channel && !channel_irq;
	endproperty
	a_idle: assert property (p_idle) else $error("bad idle output");
endmodule // pcc_checker

bind pcc_top pcc_checker u_chk
(
	.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.primary_channel, .channel_irq, .pair_active, .partner_clock_sel,
	.partner_clear_mask
);

//--- pcc_map.vh
// Register indices, field positions, reset values for the PWM channel counter.
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// Register indices; the bus byte address is four times the index.
`define PCC_IDX_COUNT_LOW    16'hf8a4
`define PCC_IDX_COUNT_HIGH   16'hf8a5
`define PCC_IDX_SETUP_ZERO   16'hf8a6
`define PCC_IDX_RUN_STATUS   16'hf8a7
`define PCC_IDX_COUNT_WORD   16'hf8aa
`define PCC_IDX_PAIR_MODE    16'hf8ab

// Bus geometry.
`define PCC_ADDR_W           18
`define PCC_IDX_W            16

// Reset values.
`define PCC_SETUP_ZERO_RST   8'h00
`define PCC_RUN_STATUS_RST   8'h40
`define PCC_PAIR_MODE_RST    8'h00
`define PCC_COUNT_RST        16'h0000

// Single-field reset values, split out of the register resets above.
`define PCC_RUN_RST          1'b0
`define PCC_FLAG_RST         1'b1
`define PCC_PAIR_RST         1'b0
`define PCC_START_MODE_RST   2'b00

// Setup register fields.
`define PCC_CLK_SEL_LO       0
`define PCC_CLK_SEL_HI       1
`define PCC_IRQ_PT_LO        2
`define PCC_IRQ_PT_HI        3
`define PCC_POLARITY         4
`define PCC_INIT_LEVEL       5
`define PCC_PAUSE_LEVEL      6
`define PCC_CLEAR_MASK       7

// Run and status register fields.
`define PCC_RUN_BIT          0
`define PCC_FLAG_BIT         6
`define PCC_STAT_BIT         7

// Pair and mode register fields.
`define PCC_READ_OK_BIT      0
`define PCC_START_MODE_LO    2
`define PCC_START_MODE_HI    3
`define PCC_PAIR_BIT         7

// Encodings.
`define PCC_CLK_LOW_SPEED    2'b00
`define PCC_CLK_TIME_BASE    2'b01
`define PCC_CLK_EXTERNAL     2'b10
`define PCC_START_SW_EXTCLR  2'b11

// Bus responses.
`define PCC_RESP_OKAY        2'b00
`define PCC_RESP_SLVERR      2'b10

`endif

//--- pcc_sync.v
// Two-stage synchroniser for one asynchronous pin.
`timescale 1ns/100ps
module pcc_sync
(
	// Clock and reset
	input  wire clk,
	input  wire rst_n,
	// Pin and result
	input  wire pin_in,
	output reg  sync_out
);

	reg         meta_r;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r   <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_r   <= pin_in;
			sync_out <= meta_r;
		end
	end

endmodule // pcc_sync

//--- pcc_top.v
// PWM channel counter, setup and run control with an AXI4-Lite slave.
`timescale 1ns/100ps
`include "pcc_map.vh"

module pcc_top
(
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// AXI4-Lite write address
	input  wire [17:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [17:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Clock sources, same domain enables
	input  wire        time_base_tick,
	input  wire        oscillator_tick,
	input  wire        system_clock_high,
	// Asynchronous pins
	input  wire        low_speed_clock,
	input  wire        external_clock_pin,
	input  wire        ext_control_pin,
	// Compare values from the period and duty logic
	input  wire [15:0] period_value,
	input  wire [15:0] duty_value,
	// Channel outputs
	output reg         primary_channel,
	output reg         channel_irq,
	output reg         counter_read_ok,
	// Partner channel coupling
	output reg         pair_active,
	output reg  [1:0]  partner_clock_sel,
	output reg         partner_clear_mask
);

	// Address decode used by both the read and the write path.
	function hit;
		input [17:0] addr;
		input [15:0] idx;
		begin
			hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// Pin synchronisers: low-speed clock, external clock, control input.
	wire [2:0]  pin_raw;
	wire [2:0]  pin_sync;

	assign pin_raw = {ext_control_pin, external_clock_pin, low_speed_clock};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_sync
			pcc_sync u_sync
			(
				.clk      (clk),
				.rst_n    (rst_n),
				.pin_in   (pin_raw[gi]),
				.sync_out (pin_sync[gi])
			);
		end
	endgenerate

	// Registers
	reg  [15:0] count_r;
	reg  [7:0]  high_hold_r;
	reg  [7:0]  setup_zero_r;
	reg         run_r;
	reg         flag_r;
	reg         pair_r;
	reg  [1:0]  start_mode_r;
	reg  [2:0]  pin_prev_r;
	reg         ctl_smp_r;
	reg         ctl_seen_r;
	reg         aw_full_r;
	reg         w_full_r;
	reg  [17:0] aw_addr_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;

	wire [1:0]  clk_sel;
	wire [1:0]  irq_pt;
	wire        neg_logic;
	wire        init_level;
	wire        pause_level;
	wire        clr_mask;

	assign clk_sel     = setup_zero_r[`PCC_CLK_SEL_HI:`PCC_CLK_SEL_LO];
	assign irq_pt      = setup_zero_r[`PCC_IRQ_PT_HI:`PCC_IRQ_PT_LO];
	assign neg_logic   = setup_zero_r[`PCC_POLARITY];
	assign init_level  = setup_zero_r[`PCC_INIT_LEVEL];
	assign pause_level = setup_zero_r[`PCC_PAUSE_LEVEL];
	assign clr_mask    = setup_zero_r[`PCC_CLEAR_MASK];

	// Rising edges of the synchronised low-speed and external clock pins become one-cycle enables.
	wire        ls_rise;
	wire        ext_rise;

	assign ls_rise  = pin_sync[0] & ~pin_prev_r[0];
	assign ext_rise = pin_sync[1] & ~pin_prev_r[1];

	// Count enable from the selected clock; code 11 never counts.
	reg         count_tick;
	always @*
	begin
		case (clk_sel)
			`PCC_CLK_LOW_SPEED: count_tick = ls_rise;
			`PCC_CLK_TIME_BASE: count_tick = time_base_tick;
			`PCC_CLK_EXTERNAL:  count_tick = ext_rise;
			default:            count_tick = 1'b0;
		endcase
	end

	wire        clk_valid;
	wire        counting;

	assign clk_valid = (clk_sel != 2'b11);
	assign counting  = run_r & clk_valid;

	// External control is sampled on oscillator ticks with the time-base clock selected, else on low-speed clock rises.
	wire        sample_en;
	wire        ctl_edge;
	wire        ext_clear;

	assign sample_en = (clk_sel == `PCC_CLK_TIME_BASE) ? oscillator_tick
	                                                   : ls_rise;
	// The first sample after reset only primes the history.
	assign ctl_edge  = sample_en & ctl_seen_r & (pin_sync[2] != ctl_smp_r);
	assign ext_clear = ctl_edge & counting
	                 & (start_mode_r == `PCC_START_SW_EXTCLR)
	                 & ~(clr_mask & flag_r);

	// Compare events.
	wire        period_hit;
	wire        duty_hit;

	assign period_hit = count_tick & counting & (count_r == period_value);
	assign duty_hit   = count_tick & counting & (count_r == duty_value);

	// Bus write path: address and data are taken in either order.
	wire        aw_take;
	wire        w_take;
	wire        do_wr;
	wire        wr_lane0;

	assign aw_take  = s_axi_awvalid & s_axi_awready;
	assign w_take   = s_axi_wvalid & s_axi_wready;
	assign do_wr    = aw_full_r & w_full_r & ~s_axi_bvalid;
	assign wr_lane0 = do_wr & w_strb_r[0];

	wire        wr_low;
	wire        wr_high;
	wire        wr_word;
	wire        wr_setup;
	wire        wr_run;
	wire        wr_pair;
	wire        wr_mapped;
	wire        count_wr;

	assign wr_low    = hit(aw_addr_r, `PCC_IDX_COUNT_LOW);
	assign wr_high   = hit(aw_addr_r, `PCC_IDX_COUNT_HIGH);
	assign wr_word   = hit(aw_addr_r, `PCC_IDX_COUNT_WORD);
	assign wr_setup  = hit(aw_addr_r, `PCC_IDX_SETUP_ZERO);
	assign wr_run    = hit(aw_addr_r, `PCC_IDX_RUN_STATUS);
	assign wr_pair   = hit(aw_addr_r, `PCC_IDX_PAIR_MODE);
	assign wr_mapped = wr_low | wr_high | wr_word | wr_setup | wr_run
	                 | wr_pair;
	assign count_wr  = wr_lane0 & (wr_low | wr_high | wr_word);

	// Bus read path.
	wire        ar_take;
	wire        rd_low;
	wire        rd_word;

	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rd_low  = ar_take & hit(s_axi_araddr, `PCC_IDX_COUNT_LOW);
	assign rd_word = ar_take & hit(s_axi_araddr, `PCC_IDX_COUNT_WORD);

	wire        run_wr_val;
	wire        run_fall;

	assign run_wr_val = w_data_r[`PCC_RUN_BIT];
	assign run_fall   = wr_lane0 & wr_run & run_r & ~run_wr_val;

	// Read data mux; reserved bits read as zero.
	reg  [31:0] rd_data;
	reg         rd_err;
	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (hit(s_axi_araddr, `PCC_IDX_COUNT_LOW))
			rd_data[7:0] = count_r[7:0];
		else if (hit(s_axi_araddr, `PCC_IDX_COUNT_HIGH))
			rd_data[7:0] = high_hold_r;
		else if (hit(s_axi_araddr, `PCC_IDX_COUNT_WORD))
			rd_data[15:0] = count_r;
		else if (hit(s_axi_araddr, `PCC_IDX_SETUP_ZERO))
			rd_data[7:0] = setup_zero_r;
		else if (hit(s_axi_araddr, `PCC_IDX_RUN_STATUS))
		begin
			rd_data[`PCC_STAT_BIT] = counting;
			rd_data[`PCC_FLAG_BIT] = flag_r;
			rd_data[`PCC_RUN_BIT]  = run_r;
		end
		else if (hit(s_axi_araddr, `PCC_IDX_PAIR_MODE))
		begin
			rd_data[`PCC_PAIR_BIT] = pair_r;
			rd_data[`PCC_START_MODE_HI:`PCC_START_MODE_LO] = start_mode_r;
			rd_data[`PCC_READ_OK_BIT] = counter_read_ok;
		end
		else
			rd_err = 1'b1;
	end

	// Level that the output starts from, before polarity.
	wire        start_level;
	assign start_level = ~init_level;

	// Bus handshake registers.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PCC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `PCC_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			aw_addr_r     <= 18'h00000;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
		end
		else
		begin
			if (aw_take)
				aw_addr_r <= s_axi_awaddr;
			if (w_take)
			begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			aw_full_r     <= (aw_full_r | aw_take) & ~do_wr;
			w_full_r      <= (w_full_r | w_take) & ~do_wr;
			s_axi_awready <= ~((aw_full_r | aw_take) & ~do_wr);
			s_axi_wready  <= ~((w_full_r | w_take) & ~do_wr);
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? `PCC_RESP_OKAY
				                          : `PCC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (ar_take)
			begin
				s_axi_rvalid  <= 1'b1;
				s_axi_arready <= 1'b0;
				s_axi_rdata   <= rd_data;
				s_axi_rresp   <= rd_err ? `PCC_RESP_SLVERR
				                        : `PCC_RESP_OKAY;
			end
			else if (s_axi_rvalid & s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end

	// Control registers written by software.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			setup_zero_r <= `PCC_SETUP_ZERO_RST;
			run_r        <= `PCC_RUN_RST;
			pair_r       <= `PCC_PAIR_RST;
			start_mode_r <= `PCC_START_MODE_RST;
		end
		else if (wr_lane0)
		begin
			if (wr_setup)
				setup_zero_r <= w_data_r[7:0];
			if (wr_run)
				run_r <= run_wr_val;
			if (wr_pair)
			begin
				pair_r       <= w_data_r[`PCC_PAIR_BIT];
				start_mode_r <= w_data_r[3:2];
			end
		end
	end

	// Counter, high-byte latch and output flag.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_r     <= `PCC_COUNT_RST;
			high_hold_r <= 8'h00;
			flag_r      <= `PCC_FLAG_RST;
		end
		else
		begin
			// A software write beats a same-cycle count or clear.
			if (count_wr)
				count_r <= `PCC_COUNT_RST;
			else if (ext_clear)
				count_r <= `PCC_COUNT_RST;
			else if (period_hit)
				count_r <= `PCC_COUNT_RST;
			else if (count_tick & counting)
				count_r <= count_r + 16'h0001;
			if (rd_low | rd_word)
				high_hold_r <= count_r[15:8];
			if (count_wr)
				flag_r <= 1'b1;
			else if (run_fall & pause_level)
				flag_r <= start_level;
			else if (ext_clear | period_hit)
				flag_r <= 1'b1;
			else if (duty_hit)
				flag_r <= 1'b0;
		end
	end

	// Pin edge history and external control sampling.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_prev_r <= 3'b000;
			ctl_smp_r  <= 1'b0;
			ctl_seen_r <= 1'b0;
		end
		else
		begin
			pin_prev_r <= pin_sync;
			if (sample_en)
			begin
				ctl_smp_r  <= pin_sync[2];
				ctl_seen_r <= 1'b1;
			end
		end
	end

	// Registered outputs.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			primary_channel    <= 1'b1;
			channel_irq        <= 1'b0;
			counter_read_ok    <= 1'b1;
			pair_active        <= 1'b0;
			partner_clock_sel  <= 2'b00;
			partner_clear_mask <= 1'b0;
		end
		else
		begin
			// The flag is taken as the high phase in positive logic.
			primary_channel <= flag_r ^ neg_logic;
			channel_irq     <= irq_pt[1] ? (period_hit | duty_hit)
			                 : irq_pt[0] ? duty_hit
			                             : period_hit;
			// A stopped counter is always readable.
			counter_read_ok <= ~counting
			                 | (clk_sel == `PCC_CLK_LOW_SPEED)
			                 | ((clk_sel == `PCC_CLK_TIME_BASE)
			                    & system_clock_high);
			pair_active        <= pair_r;
			partner_clock_sel  <= pair_r ? clk_sel : 2'b00;
			partner_clear_mask <= pair_r & clr_mask;
		end
	end

endmodule // pcc_top

//--- tb.sv
// Self-checking bench for the PWM channel counter.
`timescale 1ns/100ps
`include "pcc_map.vh"
module tb;
	reg         clk;
	reg         rst_n;
	reg  [17:0] awaddr;
	reg         awvalid;
	reg  [31:0] wdata;
	reg         wvalid;
	reg  [17:0] araddr;
	reg         arvalid;
	reg         tb_tick;
	reg  [3:0]  pins;
	reg         sys_hi;
	reg  [31:0] seed;
	wire        awready;
	wire        wready;
	wire        bvalid;
	wire        arready;
	wire        rvalid;
	wire [1:0]  bresp;
	wire [1:0]  rresp;
	wire [31:0] rdata;
	wire        pwm_out;
	wire        rd_ok;
	wire        pr_act;
	wire [1:0]  pr_sel;
	wire        irq;
	wire        pr_msk;
	reg  [15:0] per;
	reg  [15:0] duty;
	integer     irqs = 0;
	integer     base;
	integer     exp_irq;
	integer     flg;
	integer     m;
	integer     v;
	integer     miscompares;
	integer     checks;
	integer     cyc;
	integer     cnt;
	integer     hold;
	integer     n;
	integer     i;

	// Byte strobes and both ready inputs are fixed.
	pcc_top dut
	(
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.time_base_tick(tb_tick), .oscillator_tick(pins[0]),
		.system_clock_high(sys_hi), .low_speed_clock(pins[1]),
		.external_clock_pin(pins[2]), .ext_control_pin(pins[3]),
		.period_value(per), .duty_value(duty),
		.primary_channel(pwm_out), .channel_irq(irq),
		.counter_read_ok(rd_ok),
		.pair_active(pr_act), .partner_clock_sel(pr_sel),
		.partner_clear_mask(pr_msk)
	);

	// Counts the one-cycle interrupt pulses for the model to compare.
	always @(posedge clk)
		if (irq === 1'b1)
			irqs = irqs + 1;

	initial
		clk = 1'b0;
	always #5 clk = ~clk;

	function [31:0] rnd(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			rnd = x ^ (x << 5);
		end
	endfunction

	task end_of_test;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp)
			begin
				miscompares = miscompares + 1;
				$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask

	// The upper data bytes are random on purpose: only the low byte is used.
	task wr(input [15:0] idx, input [7:0] d);
		begin
			seed = rnd(seed);
			awaddr <= {idx, 2'b00};
			wdata <= {seed[31:8], d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			@(posedge clk);
			while (!bvalid)
			begin
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				@(posedge clk);
			end
			chk("bresp", bresp, 2'b00);
		end
	endtask

	task rc(input [15:0] idx, input [31:0] exp, input [1:0] er);
		begin
			araddr <= {idx, 2'b00};
			arvalid <= 1'b1;
			@(posedge clk);
			while (!rvalid)
			begin
				if (arready)
					arvalid <= 1'b0;
				@(posedge clk);
			end
			chk("rdata", rdata, exp);
			chk("rresp", rresp, er);
		end
	endtask

	// Gives exactly k time-base ticks with random gaps and noisy pins.
	task ticks(input integer k);
		begin
			while (k > 0)
			begin
				@(posedge clk);
				seed = rnd(seed);
				tb_tick <= seed[0];
				pins <= {1'b0, seed[2:1], 1'b0};
				k = k - seed[0];
			end
			@(posedge clk);
			tb_tick <= 1'b0;
			pins <= 4'h0;
			repeat (3) @(posedge clk);
		end
	endtask

	// Sets the control pin, lets it settle, then gives one sampling tick.
	task osc(input ctl);
		begin
			pins <= {ctl, 3'b000};
			repeat (3) @(posedge clk);
			pins <= {ctl, 3'b001};
			@(posedge clk);
			pins <= {ctl, 3'b000};
			repeat (3) @(posedge clk);
		end
	endtask

	// Cuts a hang short; the normal run needs well under 10000 cycles.
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc > 20000)
		begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end

	initial
	begin
		miscompares = 0;
		checks = 0;
		cyc = 0;
		seed = 32'hf0ad7515;
		rst_n = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = 18'h00000;
		araddr = 18'h00000;
		wdata = 32'h00000000;
		tb_tick = 1'b0;
		pins = 4'h0;
		sys_hi = 1'b1;
		per = 16'hffff;
		duty = 16'hffff;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rc(`PCC_IDX_SETUP_ZERO, 32'h00, 2'b00);
		rc(`PCC_IDX_RUN_STATUS, 32'h40, 2'b00);
		rc(`PCC_IDX_COUNT_LOW, 32'h00, 2'b00);
		rc(`PCC_IDX_COUNT_HIGH, 32'h00, 2'b00);
		rc(16'hf8a8, 32'h00, 2'b10);
		wr(`PCC_IDX_SETUP_ZERO, 8'h01);
		wr(`PCC_IDX_PAIR_MODE, 8'h80);
		wr(`PCC_IDX_RUN_STATUS, 8'h01);
		sys_hi <= 1'b0;
		repeat (3) @(posedge clk);
		chk("read_ok", rd_ok, 1'b0);
		sys_hi <= 1'b1;
		repeat (3) @(posedge clk);
		chk("read_ok", rd_ok, 1'b1);
		chk("pair_sel", pr_sel, 2'b01);
		chk("pair_act", pr_act, 1'b1);
		cnt = 0;
		for (i = 0; i < 3; i = i + 1)
		begin
			seed = rnd(seed);
			n = 256 + seed[8:0];
			ticks(n);
			cnt = cnt + n;
			hold = cnt / 256;
			rc(`PCC_IDX_COUNT_LOW, cnt % 256, 2'b00);
			ticks(300);
			cnt = cnt + 300;
			rc(`PCC_IDX_COUNT_HIGH, hold, 2'b00);
			rc(`PCC_IDX_COUNT_WORD, cnt, 2'b00);
			rc(`PCC_IDX_RUN_STATUS, 32'hc1, 2'b00);
			wr(i == 1 ? `PCC_IDX_COUNT_HIGH : `PCC_IDX_COUNT_LOW, seed[7:0]);
			cnt = 0;
			rc(`PCC_IDX_COUNT_WORD, 32'h00, 2'b00);
		end
		wr(`PCC_IDX_SETUP_ZERO, 8'h13);
		ticks(20);
		rc(`PCC_IDX_COUNT_WORD, 32'h00, 2'b00);
		rc(`PCC_IDX_RUN_STATUS, 32'h41, 2'b00);
		chk("pwm_out", pwm_out, 1'b0);
		chk("pair_sel", pr_sel, 2'b11);
		wr(`PCC_IDX_SETUP_ZERO, 8'h61);
		wr(`PCC_IDX_RUN_STATUS, 8'h00);
		repeat (3) @(posedge clk);
		chk("pwm_out", pwm_out, 1'b0);
		rc(`PCC_IDX_RUN_STATUS, 32'h00, 2'b00);
		wr(`PCC_IDX_COUNT_LOW, 8'h5a);
		repeat (3) @(posedge clk);
		chk("pwm_out", pwm_out, 1'b1);
		rc(`PCC_IDX_RUN_STATUS, 32'h40, 2'b00);
		// Interrupt point modes against a short period and duty.
		seed = rnd(seed);
		per <= 16'h0005 + {13'h0000, seed[2:0]};
		duty <= 16'h0002;
		wr(`PCC_IDX_RUN_STATUS, 8'h01);
		for (m = 0; m < 3; m = m + 1)
		begin
			wr(`PCC_IDX_SETUP_ZERO, {4'h0, m[1:0], 2'b01});
			wr(`PCC_IDX_COUNT_LOW, 8'h00);
			base = irqs;
			exp_irq = 0;
			flg = 1;
			for (v = 0; v < 40; v = v + 1)
			begin
				n = v % (per + 1);
				if ((n == per && m != 1) || (n == duty && m != 0))
					exp_irq = exp_irq + 1;
				if (n == per)
					flg = 1;
				else if (n == duty)
					flg = 0;
			end
			ticks(40);
			chk("irqs", irqs - base, exp_irq);
			chk("pwm_out", pwm_out, flg);
			rc(`PCC_IDX_COUNT_WORD, 40 % (per + 1), 2'b00);
		end
		// External clear in start mode 11, masked while the flag is high.
		per <= 16'hffff;
		duty <= 16'hffff;
		wr(`PCC_IDX_SETUP_ZERO, 8'h01);
		wr(`PCC_IDX_PAIR_MODE, 8'h8c);
		osc(1'b0);
		wr(`PCC_IDX_COUNT_LOW, 8'h00);
		ticks(7);
		wr(`PCC_IDX_SETUP_ZERO, 8'h81);
		osc(1'b1);
		rc(`PCC_IDX_COUNT_WORD, 32'h07, 2'b00);
		chk("pair_mask", pr_msk, 1'b1);
		wr(`PCC_IDX_SETUP_ZERO, 8'h01);
		osc(1'b0);
		rc(`PCC_IDX_COUNT_WORD, 32'h00, 2'b00);
		// Low-speed pin counting with a slow system clock.
		sys_hi <= 1'b0;
		wr(`PCC_IDX_SETUP_ZERO, 8'h00);
		wr(`PCC_IDX_COUNT_LOW, 8'h00);
		seed = rnd(seed);
		n = 3 + seed[3:0];
		repeat (n)
		begin
			@(posedge clk);
			pins <= 4'h2;
			@(posedge clk);
			pins <= 4'h0;
		end
		repeat (4) @(posedge clk);
		chk("read_ok", rd_ok, 1'b1);
		repeat (2) rc(`PCC_IDX_COUNT_WORD, n, 2'b00);
		sys_hi <= 1'b1;
		end_of_test;
	end
endmodule // tb
